// file: src/bscl_channel.sv
// One buck channel: trim, peak scaling, over-current and switch control
// Function
// - Reset loads hot trim base into trim
// - Deltas are signed four-bit, sign-extended
// - Peak target scaled by trim ratio
// - Low output: zero cross ends off time
// - Zero cross decides low side on/off
// - High-side gate comparator permits low side
// - Continuous mode: first event turns on
// - Over-current periods counted to limit plus one
// - Counter cleared on disable and dimming
// - Channel held off until the period start after the flag read
// - Overdrive forces high side on
// - Reverse control, discontinuous mode only: zero cross turns off
// - Reverse allowed: stay on till off end
// - Low output, sync off: driver off
// - Low output, sync on: normal operation
// - Drive disabled holds pre-driver low
// - Low-side gate-low comparator output provided
// - Range applied after threshold update
`timescale 1ns/10ps
`default_nettype none
module bscl_channel
	import bscl_pkg::*;
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                sys_rst,
	// Factory constants
	input  wire logic [TRIM_W-1:0]   hot_trim_base,
	input  wire logic [DELTA_W-1:0]  range_trim_delta,
	// Software trim write
	input  wire logic                trim_wr,
	input  wire logic [TRIM_W-1:0]   trim_wdata,
	// Current setting
	input  wire logic                thr_wr,
	input  wire logic [THR_W-1:0]    thr_wdata,
	input  wire logic                range_wr,
	input  wire logic [RANGE_W-1:0]  range_wdata,
	input  wire logic [15:0]         range_base,
	input  wire logic [7:0]          range_step,
	// Channel control
	input  wire logic                channel_enable,
	input  wire logic                dim_cycle,
	input  wire logic                period_start,
	input  wire logic                off_phase,
	input  wire logic                off_time_done,
	input  wire logic [OC_LIM_W-1:0] overcurrent_count_limit,
	input  wire logic                flag_read,
	// Analog status
	input  wire logic                low_output_indication,
	input  wire bscl_cmp_s           cmp,
	input  wire bscl_ls_cfg_s        ls_cfg,
	// Results
	output logic [TRIM_W-1:0]        peak_trim_value,
	output logic [DELTA_W+TRIM_W-5:0] delta_ext,
	output logic [THR_W-1:0]         peak_threshold_code,
	output logic [RANGE_W-1:0]       current_range_select,
	output logic [TARGET_W-1:0]      peak_target,
	output logic                     overcurrent_flag,
	output logic                     hs_on,
	output logic                     ls_drive,
	output logic                     ls_gate_low,
	output logic                     off_end
);
	// Registers
	logic [TRIM_W-1:0]   trim_ff;
	logic [THR_W-1:0]    thr_ff;
	logic [RANGE_W-1:0]  range_ff;
	logic [RANGE_W-1:0]  range_pend_ff;
	logic                pend_ff;
	logic [OC_CNT_W-1:0] oc_cnt_ff;
	logic                flag_ff;
	logic                hold_ff;
	logic                rel_ff;
	logic                hs_ff;
	logic                ls_ff;
	logic                glow_ff;
	logic                oend_ff;
	logic                load_ff;
	logic [6:0]          dext_ff;
	// Next values and decodes
	wire logic [OC_CNT_W-1:0] nxt_oc_cnt;
	wire logic [OC_CNT_W-1:0] oc_goal_w;
	wire logic                oc_hit_w;
	wire logic                ls_req_w;
	wire logic                zc_end_w;

	// Trim: reset arms a load of the factory base on the next edge
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			load_ff <= 1'b1;
		else
			load_ff <= 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			trim_ff <= '0;
		else if (load_ff)
			trim_ff <= hot_trim_base;
		else if (trim_wr)
			trim_ff <= trim_wdata;
	end

	// Sign-extended delta offered to software for its sums
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			dext_ff <= '0;
		else
			dext_ff <= bscl_sext(range_trim_delta);
	end

	// Range change waits until a threshold write has landed
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			thr_ff        <= THR_RST;
			range_ff      <= RANGE_RST;
			range_pend_ff <= RANGE_RST;
			pend_ff       <= 1'b0;
		end
		else
		begin
			if (thr_wr)
				thr_ff <= thr_wdata;
			if (range_wr)
				range_pend_ff <= range_wdata;
			if (range_wr)
				pend_ff <= 1'b1;
			else if (thr_wr)
				pend_ff <= 1'b0;
			if (pend_ff && thr_wr)
				range_ff <= range_pend_ff;
		end
	end

	// Peak target from base, step, threshold and trim
	bscl_peak_scale u_scale (
		.ref_clk             (ref_clk),
		.sys_rst             (sys_rst),
		.range_base          (range_base),
		.range_step          (range_step),
		.peak_threshold_code (thr_ff),
		.peak_trim_value     (trim_ff),
		.peak_target         (peak_target)
	);

	// Over-current counter saturates at limit plus one
	assign oc_goal_w  = OC_CNT_W'(overcurrent_count_limit) + 3'h1;
	assign oc_hit_w   = (oc_cnt_ff == oc_goal_w);
	assign nxt_oc_cnt = (period_start && cmp.peak_over_limit && !oc_hit_w)
		? oc_cnt_ff + 3'h1 : oc_cnt_ff;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !channel_enable || dim_cycle)
			oc_cnt_ff <= OC_CNT_RST;
		else if (rel_ff && period_start)
			oc_cnt_ff <= OC_CNT_RST;
		else
			oc_cnt_ff <= nxt_oc_cnt;
	end

	// Flag: a new hit wins over the read that clears it
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			flag_ff <= 1'b0;
			hold_ff <= 1'b0;
			rel_ff  <= 1'b0;
		end
		else
		begin
			if (oc_hit_w && !hold_ff)
				flag_ff <= 1'b1;
			else if (flag_read)
				flag_ff <= 1'b0;
			if (oc_hit_w && !hold_ff)
				hold_ff <= 1'b1;
			else if (rel_ff && period_start)
				hold_ff <= 1'b0;
			if (hold_ff && flag_read && flag_ff)
				rel_ff <= 1'b1;
			else if (period_start)
				rel_ff <= 1'b0;
		end
	end

	// Low side decision
	bscl_ls_predrv u_ls (
		.ref_clk               (ref_clk),
		.sys_rst               (sys_rst),
		.off_phase             (off_phase & channel_enable & ~hold_ff),
		.low_output_indication (low_output_indication),
		.cmp                   (cmp),
		.cfg                   (ls_cfg),
		.ls_on                 (ls_req_w)
	);

	// Low output: off time terminated by zero cross
	assign zc_end_w = low_output_indication & off_phase & cmp.zero_cross;

	// Output stage registers
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			hs_ff   <= 1'b0;
			ls_ff   <= 1'b0;
			glow_ff <= 1'b1;
			oend_ff <= 1'b0;
		end
		else
		begin
			hs_ff   <= cmp.overdrive | (channel_enable & ~hold_ff & ~off_phase);
			ls_ff   <= ls_req_w & ~cmp.overdrive & ~off_time_done;
			glow_ff <= cmp.ls_gate_low;
			oend_ff <= zc_end_w | off_time_done;
		end
	end

	assign peak_trim_value      = trim_ff;
	assign delta_ext            = dext_ff;
	assign peak_threshold_code  = thr_ff;
	assign current_range_select = range_ff;
	assign overcurrent_flag     = flag_ff;
	assign hs_on                = hs_ff;
	assign ls_drive             = ls_ff;
	assign ls_gate_low          = glow_ff;
	assign off_end              = oend_ff;
endmodule : bscl_channel
`default_nettype wire

// file: src/bscl_ls_predrv.sv
// Low side pre-driver decision logic
`timescale 1ns/10ps
`default_nettype none
module bscl_ls_predrv
	import bscl_pkg::*;
(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// Phase and status
	input  wire logic         off_phase,
	input  wire logic         low_output_indication,
	input  wire bscl_cmp_s    cmp,
	input  wire bscl_ls_cfg_s cfg,
	// Gate request
	output logic              ls_on
);
	// Blocked marks a zero-cross turn-off in discontinuous mode this off time
	logic                     on_ff;
	logic                     blk_ff;
	wire logic                allowed_w;
	wire logic                start_w;
	wire logic                zc_off_w;

	// Low output voltage disables the driver unless sync is enabled
	assign allowed_w = cfg.low_side_drive_enable
		& (~low_output_indication | cfg.low_output_sync_enable);
	// First of zero cross or high-side gate event turns on
	assign start_w   = off_phase & (cmp.zero_cross | cmp.hs_gate_at_vt);
	// Reverse current blocking only in discontinuous mode with control active
	assign zc_off_w  = cfg.discontinuous & ~cfg.reverse_current_allow
		& cmp.zero_cross & on_ff;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			on_ff  <= 1'b0;
			blk_ff <= 1'b0;
		end
		else
		begin
			blk_ff <= off_phase & (blk_ff | zc_off_w);
			if (!allowed_w || !off_phase || zc_off_w || blk_ff)
				on_ff <= 1'b0;
			else if (start_w)
				on_ff <= 1'b1;
		end
	end

	// Gated combinationally so a disable acts at once
	assign ls_on = on_ff & allowed_w;
endmodule : bscl_ls_predrv
`default_nettype wire

// file: src/bscl_peak_scale.sv
// Peak current target scaling by the trim register
`timescale 1ns/10ps
`default_nettype none
module bscl_peak_scale
	import bscl_pkg::*;
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                sys_rst,
	// Inputs
	input  wire logic [15:0]         range_base,
	input  wire logic [7:0]          range_step,
	input  wire logic [THR_W-1:0]    peak_threshold_code,
	input  wire logic [TRIM_W-1:0]   peak_trim_value,
	// Scaled target
	output logic      [TARGET_W-1:0] peak_target
);
	// Unscaled target and trim offset against the neutral code
	wire logic [TARGET_W-1:0]        raw_w;
	wire logic signed [8:0]          off_w;
	wire logic signed [47:0]         num_w;
	wire logic signed [47:0]         res_w;
	logic      [TARGET_W-1:0]        target_ff;

	// Both factors widened first so the product is never cut to the operand width
	assign raw_w = TARGET_W'(range_base) + TARGET_W'(range_step) * TARGET_W'(peak_threshold_code);
	assign off_w = $signed({2'h0, peak_trim_value}) - $signed({2'h0, TRIM_MID});
	// target * (1 + 0.4*(trim-63)/63) = target*(630 + 4*off)/630
	assign num_w = $signed({24'h0, raw_w}) * ($signed(48'(SCALE_DEN))
		+ $signed(48'(SCALE_NUM)) * 48'(off_w));
	assign res_w = num_w / $signed(48'(SCALE_DEN));

	// Registered so the divider path is not on the output
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			target_ff <= '0;
		else
			target_ff <= res_w[TARGET_W-1:0];
	end

	assign peak_target = target_ff;
endmodule : bscl_peak_scale
`default_nettype wire

// file: src/bscl_pkg.sv
// Shared constants and carrier types for the buck switch control logic
package bscl_pkg;

	// Peak trim register layout and neutral point of the scaling
	localparam int          TRIM_W       = 7;
	localparam int          DELTA_W      = 4;
	localparam int          THR_W        = 9;
	localparam int          RANGE_W      = 3;
	localparam int          OC_LIM_W     = 2;
	localparam int          OC_CNT_W     = 3;
	localparam logic [6:0]  TRIM_MID     = 7'h3f;
	// Scale numerator is 0.4 in units of one tenth, denominator 63 trim codes in the same units (630)
	localparam logic [3:0]  SCALE_NUM    = 4'h4;
	localparam logic [9:0]  SCALE_DEN    = 10'h276;
	localparam int          TARGET_W     = 24;
	localparam logic [2:0]  OC_CNT_RST   = 3'h0;
	localparam logic [2:0]  RANGE_RST    = 3'h0;
	localparam logic [8:0]  THR_RST      = 9'h000;

	// Comparator inputs that belong to one channel
	typedef struct packed {
		logic zero_cross;
		logic hs_gate_at_vt;
		logic overdrive;
		logic ls_gate_low;
		logic peak_over_limit;
	} bscl_cmp_s;

	// Static configuration of the low side driver
	typedef struct packed {
		logic low_side_drive_enable;
		logic reverse_current_allow;
		logic low_output_sync_enable;
		logic discontinuous;
	} bscl_ls_cfg_s;

	// Sign extension of a per-range delta to the trim width
	function automatic logic [6:0] bscl_sext(input logic [3:0] d);
		bscl_sext = {{3{d[3]}}, d};
	endfunction : bscl_sext

endpackage : bscl_pkg

// file: verification/bscl_channel_properties.sv
// Concurrent checks on the ports of one buck channel
`timescale 1ns/10ps
`default_nettype none
module bscl_channel_properties
	import bscl_pkg::*;
(
	// Clock and reset
	input wire logic			ref_clk,
	input wire logic			sys_rst,
	// Watched inputs
	input wire logic [TRIM_W-1:0]	hot_trim_base,
	input wire logic			thr_wr,
	input wire logic			range_wr,
	input wire logic [15:0]		range_base,
	input wire logic [7:0]		range_step,
	input wire logic			period_start,
	input wire logic			off_phase,
	input wire logic			off_time_done,
	input wire logic			low_output_indication,
	input wire bscl_cmp_s		cmp,
	input wire bscl_ls_cfg_s		ls_cfg,
	// Watched outputs
	input wire logic [TRIM_W-1:0]	peak_trim_value,
	input wire logic [THR_W-1:0]	peak_threshold_code,
	input wire logic [RANGE_W-1:0]	current_range_select,
	input wire logic [TARGET_W-1:0]	peak_target,
	input wire logic			overcurrent_flag,
	input wire logic			hs_on,
	input wire logic			ls_drive
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// Helper terms; 32 bits keep the scaled product free of overflow
	wire logic [31:0] pt_exp = (32'(range_base) + 32'(range_step) * 32'(peak_threshold_code))
		* (32'h17a + 32'h4 * 32'(peak_trim_value)) / 32'(SCALE_DEN);
	wire logic oc_hit = period_start & cmp.peak_over_limit;
	wire logic switch_overdrive_comparator = cmp.overdrive;
	wire logic ls_go = off_phase & (cmp.zero_cross | cmp.hs_gate_at_vt) & !switch_overdrive_comparator & !off_time_done
		& ls_cfg.low_side_drive_enable & !ls_cfg.discontinuous
		& !(low_output_indication & !ls_cfg.low_output_sync_enable);

	// Turn-on needs the request seen on two edges, then the driver follows
	sequence s_ls_arm;
		ls_go ##1 ls_go;
	endsequence

	a_trim_reset_load: assert property ($past(sys_rst) && !sys_rst |=> peak_trim_value == $past(hot_trim_base)) else $error("trim not loaded after reset");
	a_range_wait_thr: assert property (range_wr && !thr_wr |=> $stable(current_range_select)) else $error("range applied without threshold");
	a_peak_target_scale: assert property (!sys_rst |=> peak_target == 24'($past(pt_exp))) else $error("peak target scaling wrong");
	a_overdrive_hs_on: assert property (switch_overdrive_comparator |=> hs_on) else $error("overdrive did not force high side");
	a_oc_hold_off: assert property (overcurrent_flag && $past(overcurrent_flag) && !$past(switch_overdrive_comparator) |-> !hs_on) else $error("channel not held off");
	a_oc_flag_cause: assert property ($rose(overcurrent_flag) |-> $past(oc_hit, 2)) else $error("flag set without over-current period");
	a_ls_disable_off: assert property (!ls_cfg.low_side_drive_enable [*3] |-> !ls_drive) else $error("disabled driver still on");
	a_low_out_off: assert property ((low_output_indication && !ls_cfg.low_output_sync_enable) [*3] |-> !ls_drive) else $error("low output driver not off");
	a_ls_first_event: assert property (s_ls_arm |=> ls_drive) else $error("low side not turned on");
endmodule : bscl_channel_properties

bind bscl_channel bscl_channel_properties chk_u (.ref_clk, .sys_rst, .hot_trim_base, .thr_wr,
	.range_wr, .range_base, .range_step, .period_start, .off_phase, .off_time_done,
	.low_output_indication, .cmp, .ls_cfg, .peak_trim_value, .peak_threshold_code,
	.current_range_select, .peak_target, .overcurrent_flag, .hs_on, .ls_drive);
`default_nettype wire

// file: verification/bscl_lsfet_model.sv
// Behavioural model of the external low side switch and its gate monitor
`timescale 1ns/10ps
`default_nettype none
module bscl_lsfet_model
(
	// Clock
	input wire logic	ref_clk,
	// Pre-driver output and gate monitor
	input wire logic	ls_drive,
	output var logic	gate_low
);
	// Gate settles within a clock; the pull-down keeps it off at start
	initial gate_low = 1'b1;
	always @(posedge ref_clk)
	begin
		gate_low <= !ls_drive;
	end
endmodule : bscl_lsfet_model
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for one buck channel
`timescale 1ns/10ps
`default_nettype none
module tb import bscl_pkg::*;;
	logic ref_clk, sys_rst, trim_wr, thr_wr, range_wr, channel_enable, dim_cycle, period_start;
	logic off_phase, off_time_done, flag_read, low_output_indication, off_end, gate_low;
	logic [6:0] hot_trim_base, trim_wdata, peak_trim_value, delta_ext;
	logic [3:0] range_trim_delta;
	logic [8:0] thr_wdata, peak_threshold_code;
	logic [2:0] range_wdata, current_range_select;
	logic [15:0] range_base;
	logic [7:0] range_step;
	logic [1:0] lim;
	logic [23:0] peak_target;
	logic overcurrent_flag, hs_on, ls_drive, ls_gate_low;
	bscl_cmp_s cmpd;
	bscl_ls_cfg_s ls_cfg;
	wire bscl_cmp_s cmp = {cmpd.zero_cross, cmpd.hs_gate_at_vt, cmpd.overdrive, gate_low,
		cmpd.peak_over_limit};
	int n_fail = 0, checked = 0, cyc = 0;
	logic [31:0] rnd = 32'hb29e;

	bscl_channel dut_u (.ref_clk, .sys_rst, .hot_trim_base, .range_trim_delta, .trim_wr,
		.trim_wdata, .thr_wr, .thr_wdata, .range_wr, .range_wdata, .range_base, .range_step,
		.channel_enable, .dim_cycle, .period_start, .off_phase, .off_time_done,
		.overcurrent_count_limit(lim), .flag_read, .low_output_indication, .cmp, .ls_cfg,
		.peak_trim_value, .delta_ext, .peak_threshold_code, .current_range_select,
		.peak_target, .overcurrent_flag, .hs_on, .ls_drive, .ls_gate_low, .off_end);
	bscl_lsfet_model fet_u (.ref_clk, .ls_drive, .gate_low);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Expected target, scale 1 + 0.4*(trim-63)/63 kept in integer form
	function automatic logic [31:0] exp_pt(input logic [31:0] b, st, th, tr);
		exp_pt = (b + st * th) * (32'h17a + 32'h4 * tr) / 32'h276;
	endfunction : exp_pt
	// Host trim for range rng at junction temperature tj, deltas packed range 4 down to 1
	function automatic logic [6:0] sw_trim(input logic [6:0] base, input logic [15:0] dl,
		input int rng, input logic [3:0] tc, input int tj);
		real kq, kl, t, dt;
		kq = 1.2e-4;
		kl = ($signed(tc) - kq * 40000.0) / -200.0;
		t = base;
		for (int r = 4; r >= rng && r >= 1; r--)
			t += $signed(dl[4*r-1 -: 4]);
		dt = tj - 155;
		t += kl * dt + kq * dt * dt;
		sw_trim = 7'($rtoi(t + 0.5));
	endfunction : sw_trim
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	// Clock and a watchdog far above the expected run of a few hundred cycles
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			summarize();
		end
	end

	initial
	begin
		{trim_wr, thr_wr, range_wr, dim_cycle, period_start, off_phase, off_time_done} = '0;
		{flag_read, low_output_indication, range_trim_delta, trim_wdata, thr_wdata} = '0;
		{range_wdata, lim, cmpd, ls_cfg} = '0;
		{channel_enable, sys_rst, hot_trim_base} = {2'h3, 7'h2a};
		{range_base, range_step} = {16'h0100, 8'h10};
		repeat (4) @(posedge ref_clk);
		tick(1);
		sys_rst = 1'b0;
		tick(2);
		chk("trim_reset", peak_trim_value, hot_trim_base);
		range_wdata = 3'h5;
		pulse(range_wr);
		tick(1);
		chk("range_early", current_range_select, 3'h0);
		// Random trims and thresholds with the extremes first
		for (int i = 0; i < 20; i++)
		begin
			rnd = lfsr(rnd);
			trim_wdata = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : rnd[6:0];
			if (i > 2 && i % 2 == 1)
				trim_wdata = sw_trim(hot_trim_base, rnd[31:16], 1 + i % 4, rnd[3:0], i * 7);
			thr_wdata = (i == 2) ? 9'h1ff : rnd[15:7];
			{range_base, range_step} = {rnd[31:16], rnd[23:16]};
			thr_wr = 1'b1;
			pulse(trim_wr);
			thr_wr = 1'b0;
			tick(2);
			chk("trim_write", peak_trim_value, trim_wdata);
			chk("range_applied", current_range_select, 3'h5);
			chk("thr_code", peak_threshold_code, thr_wdata);
			chk("peak_target", peak_target, exp_pt(range_base, range_step, thr_wdata, trim_wdata));
		end
		for (int d = 0; d < 16; d++)
		begin
			range_trim_delta = 4'(d);
			tick(2);
			chk("delta_ext", delta_ext, {{3{range_trim_delta[3]}}, range_trim_delta});
		end
		// Every count limit: no trip one hit early, trip at limit plus one
		for (int l = 0; l < 4; l++)
		begin
			lim = 2'(l);
			pulse(dim_cycle);
			cmpd.peak_over_limit = 1'b1;
			for (int k = 0; k <= l; k++)
			begin
				tick(3);
				chk("oc_early", overcurrent_flag, 1'b0);
				pulse(period_start);
			end
			tick(3);
			chk("oc_flag", overcurrent_flag, 1'b1);
			chk("oc_hold", hs_on, 1'b0);
			cmpd.peak_over_limit = 1'b0;
			pulse(flag_read);
			tick(2);
			chk("oc_read", overcurrent_flag, 1'b0);
			pulse(period_start);
		end
		// Dimming and disable both restart the count
		{lim, cmpd.peak_over_limit} = 3'h3;
		pulse(period_start);
		tick(1);
		pulse(dim_cycle);
		tick(1);
		pulse(period_start);
		channel_enable = 1'b0;
		tick(2);
		channel_enable = 1'b1;
		tick(1);
		pulse(period_start);
		tick(3);
		chk("oc_cleared", overcurrent_flag, 1'b0);
		cmpd.peak_over_limit = 1'b0;
		// Low side: each turn-on event alone, then the disable
		ls_cfg = 4'he;
		off_phase = 1'b1;
		for (int e = 0; e < 2; e++)
		begin
			{cmpd.zero_cross, cmpd.hs_gate_at_vt} = (e == 0) ? 2'h2 : 2'h1;
			tick(3);
			chk("ls_on", ls_drive, 1'b1);
			tick(2);
			chk("gate_mon", ls_gate_low, 1'b0);
			ls_cfg.low_side_drive_enable = 1'b0;
			tick(3);
			chk("ls_disabled", ls_drive, 1'b0);
			ls_cfg.low_side_drive_enable = 1'b1;
		end
		{low_output_indication, ls_cfg.low_output_sync_enable} = 2'h2;
		tick(3);
		chk("ls_low_out", ls_drive, 1'b0);
		ls_cfg.low_output_sync_enable = 1'b1;
		tick(3);
		chk("ls_low_sync", ls_drive, 1'b1);
		{low_output_indication, ls_cfg.discontinuous, cmpd.zero_cross} = 3'h3;
		tick(3);
		chk("dcm_allow", ls_drive, 1'b1);
		ls_cfg.reverse_current_allow = 1'b0;
		tick(3);
		chk("dcm_block", ls_drive, 1'b0);
		chk("off_end_hi_out", off_end, 1'b0);
		// Low output with zero cross ends the off time
		low_output_indication = 1'b1;
		tick(2);
		chk("off_end_zc", off_end, 1'b1);
		low_output_indication = 1'b0;
		// Overdrive inside the off time, where nothing else turns the high side on
		{off_phase, cmpd.overdrive} = 2'h3;
		tick(2);
		chk("hs_forced", hs_on, 1'b1);
		summarize();
	end
endmodule : tb
`default_nettype wire
